// >>> pkg/ppsram_pkg.sv
// constants and types for the pipelined synchronous sram port
package ppsram_pkg;
  localparam int unsigned ADDR_W      = 18;
  localparam int unsigned LANES       = 4;
  localparam int unsigned LANE_W      = 9;
  localparam int unsigned DATA_W      = LANES * LANE_W;
  localparam int unsigned DEPTH       = 1 << ADDR_W;
  localparam int unsigned PIPE_DEPTH  = 2;
  localparam int unsigned BURST_LEN   = 4;
  localparam logic [1:0]  BEAT_FIRST  = 2'h0;
  localparam logic [1:0]  BEAT_LAST   = 2'h3;
  localparam logic [1:0]  BEAT_STEP   = 2'h1;
  localparam logic        DIR_READ    = 1'b0;
  localparam logic        DIR_WRITE   = 1'b1;
  localparam logic        ORDER_INTLV = 1'b1;
  localparam logic        ORDER_LIN   = 1'b0;

  // burst sequencer state, one-hot
  typedef enum logic [1:0]
  {
    PPS_IDLE  = 2'b01,
    PPS_BURST = 2'b10
  } ppsram_state_e;
endpackage : ppsram_pkg

// >>> verilog/ppsram_array.sv
// storage array with byte-lane writes and a registered read port
`timescale 1ns/1ps
module ppsram_array
  import ppsram_pkg::*;
(
  // clock
  input  wire logic                          clock,
  // write port
  input  wire logic                          wr_en,
  input  wire logic [ppsram_pkg::LANES-1:0]  wr_lane,
  input  wire logic [ppsram_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [ppsram_pkg::DATA_W-1:0] wr_data,
  // read port
  input  wire logic                          rd_en,
  input  wire logic [ppsram_pkg::ADDR_W-1:0] rd_addr,
  output logic      [ppsram_pkg::DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  // each lane written only under its own enable
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    always_ff @(posedge clock)
    begin
      if (wr_en && wr_lane[g])
      begin
        mem[wr_addr][g*LANE_W +: LANE_W] <= wr_data[g*LANE_W +: LANE_W];
      end
    end
  end

  // read data held in a register
  always_ff @(posedge clock)
  begin
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : ppsram_array

// >>> verilog/ppsram_port.sv
// pipelined burst sram port: command decode, burst counter, two-stage data pipe
`timescale 1ns/1ps
module ppsram_port
  import ppsram_pkg::*;
// Notes on behaviour
// R1: address captured on enabled selected load
// R2: low address bits seed burst counter
// R3: one write enable per nine-bit lane
// R4: controller keeps lane enables valid on writes
// R5: lane enables ignored on read cycles
// R6: write data taken two cycles later
// R7: lane enables may all be tied low
// R8: clock hold freezes everything; code keeps the sleep and drive-enable synchronisers running
// R9: load direction governs following burst
// R10: data moves two cycles after command
// R11: unselected load starts deselect
// R12: bus floats two cycles after deselect
// R13: output drive input gates read data
// R14: selected load takes address and control
// R15: advance steps counter, ignores address
// R16: burst order pin picks interleaved or linear
// R17: sleep request enters standby
// R18: all else on rising clock edge
// R19: four beats per loaded address
// R20: deselect stops burst, pipeline drains
// R21: linear wraps mod four, interleave xors
(
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // command inputs
  input  wire logic [ppsram_pkg::ADDR_W-1:0] address,
  input  wire logic                          advance_not_load,
  input  wire logic                          write_not_read,
  input  wire logic                          clock_hold_n,
  input  wire logic                          chip_select1_n,
  input  wire logic                          chip_select2_high,
  input  wire logic                          chip_select3_n,
  input  wire logic [ppsram_pkg::LANES-1:0]  byte_lane_write_n,
  // static and asynchronous controls
  input  wire logic                          burst_order,
  input  wire logic                          output_drive_n,
  input  wire logic                          sleep_request,
  // data bus, split into in, out and enable
  input  wire logic [ppsram_pkg::DATA_W-1:0] data_in,
  output logic      [ppsram_pkg::DATA_W-1:0] data_out,
  output logic                               data_oe,
  // status
  output logic                               standby
);
  ppsram_state_e         state;
  ppsram_state_e         next_state;
  logic [ADDR_W-1:0]     base_addr;
  logic [1:0]            beat;
  logic                  dir;
  logic                  order;
  logic [ADDR_W-1:0]     cur_addr;
  logic                  run;
  logic                  selected;
  logic                  do_load;
  logic                  do_deselect;
  logic                  do_advance;
  logic                  cmd_valid;
  logic                  cmd_dir;
  logic [ADDR_W-1:0]     cmd_addr;
  logic [LANES-1:0]      cmd_lane;
  logic [PIPE_DEPTH-1:0] p_valid;
  logic [PIPE_DEPTH-1:0] p_dir;
  logic [ADDR_W-1:0]     p_addr [PIPE_DEPTH];
  logic [LANES-1:0]      p_lane [PIPE_DEPTH];
  logic [DATA_W-1:0]     rd_word;
  logic                  read_drive;
  logic                  sleep_s1;
  logic                  sleep_s2;
  logic                  drive_s1;
  logic                  drive_s2;

  // R18 everything runs on the rising edge; clock_hold_n gates all but the sleep and drive-enable synchronisers
  // R8 hold freezes state
  assign run = !clock_hold_n && !sleep_s2;
  // R11 any inactive select deselects
  assign selected    = !chip_select1_n && chip_select2_high && !chip_select3_n;
  // R14 selected load
  assign do_load     = run && !advance_not_load && selected;
  assign do_deselect = run && !advance_not_load && !selected;
  // R15 advance ignores address and direction
  assign do_advance  = run && advance_not_load && (state == PPS_BURST) && (beat != BEAT_LAST);

  // sleep and drive-enable pins are asynchronous, so they are synchronised
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      drive_s1 <= 1'b1;
      drive_s2 <= 1'b1;
    end
    else
    begin
      sleep_s1 <= sleep_request;
      sleep_s2 <= sleep_s1;
      drive_s1 <= output_drive_n;
      drive_s2 <= drive_s1;
    end
  end

  // R17 standby while sleep requested
  assign standby = sleep_s2;

  // burst sequencer state
  always_comb
  begin
    next_state = state;
    unique case (state)
      PPS_IDLE:
      begin
        if (do_load)
        begin
          next_state = PPS_BURST;
        end
      end
      PPS_BURST:
      begin
        // R20 deselect ends the burst
        if (do_deselect)
        begin
          next_state = PPS_IDLE;
        end
        // R19 four beats then stop
        else if (run && advance_not_load && beat == BEAT_LAST)
        begin
          next_state = PPS_IDLE;
        end
      end
      default:
      begin
        next_state = PPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= PPS_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // address, direction and order registers plus beat counter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      base_addr <= '0;
      beat      <= BEAT_FIRST;
      dir       <= DIR_READ;
      order     <= ORDER_INTLV;
    end
    // R1 capture only on enabled selected load
    else if (do_load)
    begin
      base_addr <= address;
      beat      <= BEAT_FIRST;
      // R9 direction kept for whole burst
      dir       <= write_not_read;
      // R16 order sampled per burst; pin is static anyway
      order     <= burst_order;
    end
    else if (do_advance)
    begin
      beat <= beat + BEAT_STEP;
    end
  end

  // R2 low bits seed the burst; R21 linear adds, interleave xors
  always_comb
  begin
    cur_addr = base_addr;
    if (order == ORDER_INTLV)
    begin
      cur_addr[1:0] = base_addr[1:0] ^ beat;
    end
    else
    begin
      cur_addr[1:0] = base_addr[1:0] + beat;
    end
  end

  // command presented to the pipe this edge
  always_comb
  begin
    cmd_valid = 1'b0;
    cmd_dir   = DIR_READ;
    cmd_addr  = cur_addr;
    cmd_lane  = '0;
    if (do_load)
    begin
      cmd_valid = 1'b1;
      cmd_dir   = write_not_read;
      cmd_addr  = address;
    end
    else if (do_advance)
    begin
      cmd_valid = 1'b1;
      cmd_dir   = dir;
      cmd_addr  = base_addr;
      if (order == ORDER_INTLV)
      begin
        cmd_addr[1:0] = base_addr[1:0] ^ (beat + BEAT_STEP);
      end
      else
      begin
        cmd_addr[1:0] = base_addr[1:0] + beat + BEAT_STEP;
      end
    end
    // R5 lanes ignored on reads; R3 active low per lane
    if (cmd_dir == DIR_WRITE)
    begin
      cmd_lane = ~byte_lane_write_n;
    end
  end

  // R10 two-stage pipe; R20 deselect only stops new entries
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      p_valid <= '0;
      p_dir   <= '0;
      p_addr  <= '{default: '0};
      p_lane  <= '{default: '0};
    end
    else if (run)
    begin
      p_valid[0] <= cmd_valid;
      p_dir[0]   <= cmd_dir;
      p_addr[0]  <= cmd_addr;
      p_lane[0]  <= cmd_lane;
      p_valid[1] <= p_valid[0];
      p_dir[1]   <= p_dir[0];
      p_addr[1]  <= p_addr[0];
      p_lane[1]  <= p_lane[0];
    end
  end

  // R6 write data sampled at stage two; read fetched one edge early
  ppsram_array u_array
  (
    .clock   (clock),
    .wr_en   (run && p_valid[1] && p_dir[1] == DIR_WRITE),
    .wr_lane (p_lane[1]),
    .wr_addr (p_addr[1]),
    .wr_data (data_in),
    .rd_en   (run && p_valid[0] && p_dir[0] == DIR_READ),
    .rd_addr (p_addr[0]),
    .rd_data (rd_word)
  );

  // R12 bus released unless a read sits in the final stage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      read_drive <= 1'b0;
    end
    else if (run)
    begin
      read_drive <= p_valid[0] && p_dir[0] == DIR_READ;
    end
    else if (sleep_s2)
    begin
      read_drive <= 1'b0;  // standby drops any pending drive
    end
  end

  // read data straight from the array's output register, no extra stage
  assign data_out = rd_word;
  // R13 drive only with output_drive_n low
  assign data_oe = read_drive && !drive_s2 && !sleep_s2;
endmodule : ppsram_port

// >>> testbench/ppsram_checker.sv
// pin-level assertions for the sram port
`timescale 1ns/1ps
module ppsram_checker
(
  input wire logic clock,
  input wire logic rst,
  input wire logic advance_not_load,
  input wire logic write_not_read,
  input wire logic clock_hold_n,
  input wire logic chip_select1_n,
  input wire logic chip_select2_high,
  input wire logic chip_select3_n,
  input wire logic output_drive_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic standby
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // all three selects true
  wire sel = !chip_select1_n && chip_select2_high && !chip_select3_n;
  sequence s_go; !clock_hold_n && !sleep_request; endsequence
  sequence s_rd; s_go ##0 !advance_not_load && sel && !write_not_read; endsequence
  sequence s_wr; s_go ##0 !advance_not_load && sel && write_not_read; endsequence
  sequence s_dsl; s_go ##0 !advance_not_load && !sel; endsequence
  sequence s_adv; s_go ##0 advance_not_load; endsequence
  // drive pin passes two flops, so the gate lags it by two edges
  property p_oe; data_oe |-> !$past(output_drive_n, 2); endproperty
  a_oe: assert property (p_oe) else $error("bus driven while disabled");
  property p_rd; s_rd ##1 s_go |=> data_oe || $past(output_drive_n, 2); endproperty
  a_rd: assert property (p_rd) else $error("read data missing");
  property p_wrz; s_wr ##1 s_go |=> !data_oe; endproperty
  a_wrz: assert property (p_wrz) else $error("bus driven on write");
  property p_dslz; s_dsl ##1 s_go |=> !data_oe; endproperty
  a_dslz: assert property (p_dslz) else $error("bus driven after deselect");
  property p_dsla; s_dsl ##1 s_adv ##1 s_go |=> !data_oe; endproperty
  a_dsla: assert property (p_dsla) else $error("burst kept after deselect");
  property p_dirw; s_wr ##1 s_adv ##1 s_go |=> !data_oe; endproperty
  a_dirw: assert property (p_dirw) else $error("write burst turned to read");
  property p_dirr; s_rd ##1 s_adv ##1 s_go |=> data_oe || $past(output_drive_n, 2); endproperty
  a_dirr: assert property (p_dirr) else $error("read burst beat missing");
  property p_zz; sleep_request [*3] |-> standby; endproperty
  a_zz: assert property (p_zz) else $error("no standby");
endmodule : ppsram_checker

bind ppsram_port ppsram_checker u_chk (.clock, .rst, .advance_not_load, .write_not_read, .clock_hold_n,
  .chip_select1_n, .chip_select2_high, .chip_select3_n, .output_drive_n, .sleep_request, .data_oe, .standby);

// >>> testbench/ppsram_ctrl_model.sv
// controller side: write data two cycles after each write beat
`timescale 1ns/1ps
module ppsram_ctrl_model
  import ppsram_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          clock_hold_n,
  input  wire logic                          wr_beat,
  input  wire logic [ppsram_pkg::DATA_W-1:0] wr_word,
  output logic      [ppsram_pkg::DATA_W-1:0] data_in
);
  logic [1:0] vld = 2'h0;
  logic [DATA_W-1:0] dly [2];
  logic tog = 1'b0;
  always @(posedge clock)
  begin
    tog <= !tog;
    if (!clock_hold_n)
    begin
      vld <= {vld[0], wr_beat};
      dly[1] <= dly[0];
      dly[0] <= wr_word;
    end
  end
  // released bus toggles so stale data never matches
  assign data_in = vld[1] ? dly[1] : {DATA_W{tog}};
endmodule : ppsram_ctrl_model

// >>> testbench/ppsram_port_tb.sv
// self-checking bench for the sram port
`timescale 1ns/1ps
module ppsram_port_tb;
  import ppsram_pkg::*;
  logic clock = 1'b0, rst = 1'b1, advance_not_load = 1'b0, write_not_read = 1'b0, clock_hold_n = 1'b0;
  logic chip_select1_n = 1'b1, chip_select2_high = 1'b1, chip_select3_n = 1'b0, dir = 1'b0, wr_beat = 1'b0;
  logic burst_order = 1'b0, output_drive_n = 1'b0, sleep_request = 1'b0, data_oe, standby;
  logic [ADDR_W-1:0] address = '0;
  logic [LANES-1:0] byte_lane_write_n = '0;
  logic [DATA_W-1:0] data_in, data_out, wr_word = '0;
  int n_errors = 0, checked = 0, cyc = 0;
  always #25 clock = !clock;
  ppsram_port u_dut (.clock, .rst, .address, .advance_not_load, .write_not_read, .clock_hold_n, .chip_select1_n,
    .chip_select2_high, .chip_select3_n, .byte_lane_write_n, .burst_order, .output_drive_n, .sleep_request,
    .data_in, .data_out, .data_oe, .standby);
  ppsram_ctrl_model u_ctrl (.clock, .clock_hold_n, .wr_beat, .wr_word, .data_in);
  function automatic logic [DATA_W-1:0] wd(input logic [1:0] a);
    return 36'h9_5a3c_1e70 ^ {4{7'h00, a}};
  endfunction : wd
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one command cycle, driven just after the edge
  task automatic st(input logic adv, input logic wr, input logic cs, input logic [1:0] lo,
    input logic [LANES-1:0] bw, input logic [DATA_W-1:0] d);
    @(posedge clock);
    #1;
    if (!adv)
      dir = wr && cs;
    advance_not_load = adv;
    // advance shows wrong address and direction
    write_not_read = adv ? !dir : wr;
    address = adv ? {16'hf5a3, ~lo} : {16'h0a5c, lo};
    chip_select1_n = !cs && lo == 2'h0;
    chip_select3_n = !cs && lo == 2'h1;
    chip_select2_high = cs || !lo[1];
    byte_lane_write_n = bw;
    wr_beat = dir && (adv || cs);
    wr_word = d;
  endtask : st
  task automatic t_burst(input logic wr, input logic ord, input logic [1:0] s);
    logic [1:0] a [4];
    logic adv;
    burst_order = ord;
    for (int j = 0; j < 9; j++)
    begin
      if (j < 4)
        a[j] = ord ? s ^ 2'(j) : s + 2'(j);
      adv = (j > 0 && j < 4) || j == 5;
      st(adv, wr, adv || j == 0, j < 4 ? a[j] : 2'(j), '0, j < 4 ? wd(a[j]) : '0);
      if (j >= 2 && j < 6 && !wr)
        chk(data_out, wd(a[j-2]));
      if (j >= 2)
        chk(data_oe, !wr && j < 6);
    end
    $display("burst test done");
  endtask : t_burst
  task automatic t_hold();
    st(1'b0, 1'b0, 1'b1, 2'h0, '0, '0);
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    clock_hold_n = 1'b1;
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    clock_hold_n = 1'b0;
    chk(data_oe, 1'b0);
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    chk(data_oe, 1'b1);
    chk(data_out, wd(2'h0));
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    chk(data_oe, 1'b0);
    $display("hold test done");
  endtask : t_hold
  task automatic t_off();
    output_drive_n = 1'b1;
    st(1'b0, 1'b0, 1'b1, 2'h3, '0, '0);
    repeat (2) st(1'b1, 1'b0, 1'b1, 2'h3, '0, '0);
    chk(data_oe, 1'b0);
    // drive pin is synchronised, so the bus opens two edges later
    output_drive_n = 1'b0;
    st(1'b1, 1'b0, 1'b1, 2'h3, '0, '0);
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    chk(data_oe, 1'b1);
    chk(data_out, wd(2'h1));
    st(1'b0, 1'b0, 1'b0, 2'h1, '0, '0);
    $display("drive test done");
  endtask : t_off
  task automatic t_lane();
    st(1'b0, 1'b1, 1'b1, 2'h1, 4'ha, ~wd(2'h1));
    repeat (2) st(1'b0, 1'b0, 1'b0, 2'h2, 4'h0, '0);
    st(1'b0, 1'b0, 1'b1, 2'h1, 4'h0, '0);
    repeat (3) st(1'b0, 1'b0, 1'b0, 2'h2, 4'h0, '0);
    chk(data_out, wd(2'h1) ^ 36'h0_07fc_01ff);
    $display("lane test done");
  endtask : t_lane
  task automatic t_sleep();
    chk(standby, 1'b0);
    sleep_request = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(standby, 1'b1);
    sleep_request = 1'b0;
    repeat (4) @(posedge clock);
    #1 chk(standby, 1'b0);
    $display("sleep test done");
  endtask : t_sleep
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // hang guard, tests need about 90 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 1000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    t_burst(1'b1, 1'b0, 2'h0);
    t_burst(1'b1, 1'b1, 2'h2);
    t_burst(1'b0, 1'b0, 2'h1);
    t_burst(1'b0, 1'b1, 2'h2);
    t_burst(1'b0, 1'b0, 2'h3);
    t_hold();
    t_off();
    t_lane();
    t_sleep();
    print_verdict();
  end
endmodule : ppsram_port_tb
